// [pkg/cdm_defs.vh]
`ifndef CDM_DEFS_VH
`define CDM_DEFS_VH

// ==========================================================
// array geometry
`define CDM_DEPTH 16
`define CDM_AW 4
`define CDM_W 64
`define CDM_HW 32

// ==========================================================
// command word fields
`define CDM_OPW 12
`define CDM_LOW_MSB 5
`define CDM_LOW_LSB 0
`define CDM_MSEL_MSB 8
`define CDM_MSEL_LSB 6
`define CDM_MSEL_NONE 3'h0

// ==========================================================
// control states, low six bits of the command word
`define CDM_OP_MOVE_IND 6'h0C
`define CDM_OP_MOVE_FREE 6'h0D
`define CDM_OP_MOVE_TOP 6'h0E
`define CDM_OP_CMP_FULL 6'h18
`define CDM_OP_CMP_HALF 6'h19
`define CDM_OP_CMP_LOAD 6'h1A
`define CDM_OP_NEXT 6'h1B
`define CDM_OP_CMP_TERN 6'h1C

// ==========================================================
// register port map, word indices
`define CDM_RAW 5
`define CDM_RA_CMP_LO 5'h00
`define CDM_RA_CMP_HI 5'h01
`define CDM_RA_ADDR 5'h10
`define CDM_RA_STAT 5'h11
`define CDM_RA_AREA_BIT 4
`define CDM_RA_MSEL_MSB 3
`define CDM_RA_MSEL_LSB 1
`define CDM_RA_HALF_BIT 0
`define CDM_STAT_MF_BIT 31
`define CDM_STAT_FF_BIT 30

// ==========================================================
// reset values
`define CDM_WORD_RST 64'h0000000000000000
`define CDM_HALF_RST 32'h00000000
`define CDM_ADDR_RST 4'h0
`define CDM_VALID_RST 1'b1

`endif

// [rtl/cdm_core.v]
// How it works
// R01: move-indirect with write low stores comparand into word at address_reg.
// R02: any store into array sets entry valid from entry_valid_n input.
// R03: mask select zero means no mask; else only mask-low bits change.
// R04: move-indirect with write high loads comparand from word at address_reg.
// R05: loads into comparand leave the validity pin undriven.
// R06: move-to-free stores at first empty word, only if cascade full-in low.
// R07: move-to-top-match stores comparand, masked, into top matching word.
// R08: move-from-top-match loads comparand, masked, from top matching word.
// R09: full compare matches comparand against every valid word only.
// R10: compare ignores bits whose mask bit is high; select zero compares all.
// R11: controller keeps half_select low for full compare and all moves.
// R12: bus-half compare: bus fills half chosen by half_select, register rest.
// R13: compare-and-load writes bus into comparand half, then compares whole word.
// R14: in compare-and-load the mask limits the compare, not the register write.
// R15: ternary compare uses bus and its complement as both key and mask.
// R16: ternary compare changes neither comparand nor any mask register.
// R17: compares update match_address_bus with the top matching address.
// R18: advance command steps match address to the next matching word.
// R19: match_flag_n goes high once all matches are used up.
// R20: reset empties every word and zeroes comparand and masks one to seven.
// R21: top three command bits ignored; mask selector taken from nnn field.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "cdm_defs.vh"

module cdm_core (
  input wire sys_clk,
  input wire rst_n,
  input wire ce,
  input wire cmd_sel,
  input wire [`CDM_OPW-1:0] op_code,
  input wire write_n,
  input wire addr_valid_n,
  input wire half_select,
  input wire [`CDM_HW-1:0] data_in,
  input wire cascade_full_in_n,
  input wire entry_valid_n_i,
  output reg entry_valid_n_o,
  output reg entry_valid_n_oe,
  output reg [`CDM_AW-1:0] match_address_bus,
  output reg match_flag_n,
  output reg full_flag_n,
  input wire [`CDM_RAW-1:0] reg_addr,
  input wire [`CDM_HW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`CDM_HW-1:0] reg_rdata
);

  // ==========================================================
  // storage
  reg [`CDM_W-1:0] word_mem [0:`CDM_DEPTH-1];
  reg [`CDM_DEPTH-1:0] valid_n_reg;
  reg [`CDM_W-1:0] mask_mem [1:7];
  reg [`CDM_W-1:0] comparand_reg;
  reg [`CDM_AW-1:0] address_reg;
  reg [`CDM_DEPTH-1:0] match_reg;

  // ==========================================================
  // priority encoder: lowest index is highest priority
  function [`CDM_AW-1:0] first_idx;
    input [`CDM_DEPTH-1:0] v;
    integer k;
    begin
      first_idx = `CDM_ADDR_RST;
      for (k = `CDM_DEPTH - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_idx = k[`CDM_AW-1:0];
        end
      end
    end
  endfunction

  // ==========================================================
  // command decode
  wire take = ce & cmd_sel & addr_valid_n;
  // upper three bits never looked at
  wire [5:0] op_low = op_code[`CDM_LOW_MSB:`CDM_LOW_LSB]; // R21
  wire [2:0] msel = op_code[`CDM_MSEL_MSB:`CDM_MSEL_LSB]; // R21

  reg [`CDM_W-1:0] sel_mask;
  always @* begin
    if (msel == `CDM_MSEL_NONE) begin
      sel_mask = `CDM_WORD_RST; // R03 R10
    end else begin
      sel_mask = mask_mem[msel];
    end
  end

  wire any_empty = |valid_n_reg;
  wire [`CDM_AW-1:0] free_idx = first_idx(valid_n_reg);
  wire has_match = ~match_flag_n;

  wire op_ind = take & (op_low == `CDM_OP_MOVE_IND);
  wire op_free = take & (op_low == `CDM_OP_MOVE_FREE);
  wire op_top = take & (op_low == `CDM_OP_MOVE_TOP);
  wire op_full = take & (op_low == `CDM_OP_CMP_FULL);
  wire op_half = take & (op_low == `CDM_OP_CMP_HALF);
  wire op_load = take & (op_low == `CDM_OP_CMP_LOAD);
  wire op_tern = take & (op_low == `CDM_OP_CMP_TERN);
  wire op_next = take & (op_low == `CDM_OP_NEXT) & ~write_n;

  // cascade: only the first device with room takes the store
  wire free_ok = ~cascade_full_in_n & any_empty; // R06
  // a store to the top match is dropped when nothing matched
  wire mem_wr = ~write_n & (op_ind | (op_free & free_ok) |
    (op_top & has_match)); // R01 R06 R07
  wire cmp_ld = write_n & (op_ind | (op_top & has_match)); // R04 R08
  wire do_cmp = ~write_n & (op_full | op_half | op_load | op_tern); // R17

  reg [`CDM_AW-1:0] tgt_idx;
  always @* begin
    if (op_free) begin
      tgt_idx = free_idx; // R06
    end else if (op_top) begin
      tgt_idx = match_address_bus; // R07 R08
    end else begin
      tgt_idx = address_reg; // R01 R04
    end
  end

  wire [`CDM_W-1:0] tgt_word = word_mem[tgt_idx];
  // mask-high bits keep the destination's old value
  wire [`CDM_W-1:0] store_word =
    (tgt_word & sel_mask) | (comparand_reg & ~sel_mask); // R03
  wire [`CDM_W-1:0] load_word =
    (comparand_reg & sel_mask) | (tgt_word & ~sel_mask); // R03 R04 R08

  // ==========================================================
  // search key and mask
  reg [`CDM_W-1:0] key;
  reg [`CDM_W-1:0] key_mask;
  always @* begin
    key = comparand_reg; // R09
    key_mask = sel_mask; // R10
    if (op_half | op_load) begin
      if (half_select) begin
        key = {data_in, comparand_reg[`CDM_HW-1:0]}; // R12 R13
      end else begin
        key = {comparand_reg[`CDM_W-1:`CDM_HW], data_in}; // R12 R13
      end
    end else if (op_tern) begin
      key = {~data_in, data_in}; // R15
      key_mask = {~data_in, data_in}; // R15
    end
  end

  wire [`CDM_DEPTH-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < `CDM_DEPTH; gi = gi + 1) begin : g_cmp
      // empty words never match
      assign hit[gi] = ~valid_n_reg[gi] &
        ~|((word_mem[gi] ^ key) & ~key_mask); // R09 R10
    end
  endgenerate

  reg [`CDM_DEPTH-1:0] next_vec;
  always @* begin
    next_vec = match_reg;
    next_vec[match_address_bus] = 1'b0; // R18
  end

  // ==========================================================
  // array and validity
  integer i;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `CDM_DEPTH; i = i + 1) begin
        word_mem[i] <= `CDM_WORD_RST;
        valid_n_reg[i] <= `CDM_VALID_RST; // R20
      end
    end else if (ce && mem_wr) begin
      word_mem[tgt_idx] <= store_word; // R01 R06 R07
      valid_n_reg[tgt_idx] <= entry_valid_n_i; // R02
    end
  end

  // ==========================================================
  // comparand, masks, address register, software port
  wire sw_mask = ~reg_addr[`CDM_RA_AREA_BIT] &
    (reg_addr[`CDM_RA_MSEL_MSB:`CDM_RA_MSEL_LSB] != `CDM_MSEL_NONE);
  wire [2:0] sw_msel = reg_addr[`CDM_RA_MSEL_MSB:`CDM_RA_MSEL_LSB];
  wire sw_hi = reg_addr[`CDM_RA_HALF_BIT];

  integer m;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparand_reg <= `CDM_WORD_RST; // R20
      address_reg <= `CDM_ADDR_RST;
      for (m = 1; m < 8; m = m + 1) begin
        mask_mem[m] <= `CDM_WORD_RST; // R20
      end
    end else if (ce) begin
      // a command beats a software write to the comparand
      if (cmp_ld) begin // R16
        comparand_reg <= load_word; // R04 R08
      end else if (op_load & ~write_n) begin
        // bus half lands unmasked
        if (half_select) begin
          comparand_reg[`CDM_W-1:`CDM_HW] <= data_in; // R13 R14
        end else begin
          comparand_reg[`CDM_HW-1:0] <= data_in; // R13 R14
        end
      end else if (reg_wr && reg_addr == `CDM_RA_CMP_LO) begin
        comparand_reg[`CDM_HW-1:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == `CDM_RA_CMP_HI) begin
        comparand_reg[`CDM_W-1:`CDM_HW] <= reg_wdata;
      end
      // ternary search writes nothing here
      if (reg_wr && sw_mask) begin
        if (sw_hi) begin
          mask_mem[sw_msel][`CDM_W-1:`CDM_HW] <= reg_wdata;
        end else begin
          mask_mem[sw_msel][`CDM_HW-1:0] <= reg_wdata;
        end
      end
      if (reg_wr && reg_addr == `CDM_RA_ADDR) begin
        address_reg <= reg_wdata[`CDM_AW-1:0];
      end
    end
  end

  // ==========================================================
  // match state and flags
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_reg <= {`CDM_DEPTH{1'b0}};
      match_address_bus <= `CDM_ADDR_RST;
      match_flag_n <= 1'b1;
      full_flag_n <= 1'b1;
      entry_valid_n_o <= 1'b1;
      entry_valid_n_oe <= 1'b0;
    end else if (ce) begin
      // flag lags the array by one cycle
      full_flag_n <= any_empty;
      entry_valid_n_o <= 1'b1;
      entry_valid_n_oe <= 1'b0; // R05
      if (do_cmp) begin
        match_reg <= hit;
        match_address_bus <= first_idx(hit); // R17
        match_flag_n <= ~|hit; // R19
      end else if (op_next) begin
        match_reg <= next_vec;
        match_address_bus <= first_idx(next_vec); // R18
        match_flag_n <= ~|next_vec; // R19
      end
    end
  end

  // ==========================================================
  // register read port, data one cycle after the strobe
  reg [`CDM_HW-1:0] rd_val;
  always @* begin
    rd_val = `CDM_HALF_RST;
    if (reg_addr == `CDM_RA_CMP_LO) begin
      rd_val = comparand_reg[`CDM_HW-1:0];
    end else if (reg_addr == `CDM_RA_CMP_HI) begin
      rd_val = comparand_reg[`CDM_W-1:`CDM_HW];
    end else if (reg_addr == `CDM_RA_ADDR) begin
      rd_val[`CDM_AW-1:0] = address_reg;
    end else if (reg_addr == `CDM_RA_STAT) begin
      rd_val[`CDM_AW-1:0] = match_address_bus;
      rd_val[`CDM_STAT_MF_BIT] = match_flag_n;
      rd_val[`CDM_STAT_FF_BIT] = full_flag_n;
    end else if (sw_mask) begin
      if (sw_hi) begin
        rd_val = mask_mem[sw_msel][`CDM_W-1:`CDM_HW];
      end else begin
        rd_val = mask_mem[sw_msel][`CDM_HW-1:0];
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `CDM_HALF_RST;
    end else if (ce) begin
      if (reg_rd) begin
        reg_rdata <= rd_val;
      end else begin
        reg_rdata <= `CDM_HALF_RST;
      end
    end
  end

endmodule

`default_nettype wire

// [tb/cdm_core_properties.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cdm_defs.vh"
// ==========================================================
// port checker
module cdm_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_sel,
  input wire logic [`CDM_OPW-1:0] op_code,
  input wire logic write_n,
  input wire logic addr_valid_n,
  input wire logic entry_valid_n_oe,
  input wire logic [`CDM_AW-1:0] match_address_bus,
  input wire logic match_flag_n,
  input wire logic full_flag_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic take, is_cmp, is_nxt, is_st;
  logic [5:0] cs;
  assign cs = op_code[5:0];
  assign take = ce & cmd_sel & addr_valid_n;
  assign is_nxt = take & ~write_n & (cs == `CDM_OP_NEXT);
  assign is_cmp = take & (cs inside {`CDM_OP_CMP_FULL, `CDM_OP_CMP_HALF,
    `CDM_OP_CMP_LOAD, `CDM_OP_CMP_TERN});
  assign is_st = take & ~write_n & (cs inside {`CDM_OP_MOVE_IND,
    `CDM_OP_MOVE_FREE, `CDM_OP_MOVE_TOP});
  property p_vb_off; !entry_valid_n_oe; endproperty
  a_vb_off: assert property (p_vb_off) else $error("validity pin driven");
  property p_rst;
    $rose(rst_n) |-> match_flag_n && full_flag_n && match_address_bus == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_ma_hold;
    !(is_cmp | is_nxt) |=> $stable(match_address_bus) && $stable(match_flag_n);
  endproperty
  a_ma_hold: assert property (p_ma_hold) else $error("match moved");
  property p_next_up;
    is_nxt && !match_flag_n |=>
      match_flag_n || match_address_bus > $past(match_address_bus);
  endproperty
  a_next_up: assert property (p_next_up) else $error("advance not up");
  property p_next_done; is_nxt && match_flag_n |=> match_flag_n; endproperty
  a_next_done: assert property (p_next_done) else $error("flag relit");
  property p_mf_rise; $rose(match_flag_n) |-> $past(is_cmp | is_nxt); endproperty
  a_mf_rise: assert property (p_mf_rise) else $error("flag rose alone");
  property p_mf_fall; $fell(match_flag_n) |-> $past(is_cmp); endproperty
  a_mf_fall: assert property (p_mf_fall) else $error("flag fell alone");
  // full flag lags the array by one edge
  property p_ff_fall; $fell(full_flag_n) |-> $past(is_st, 2); endproperty
  a_ff_fall: assert property (p_ff_fall) else $error("full without store");
endmodule
bind cdm_core cdm_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
  .cmd_sel(cmd_sel), .op_code(op_code), .write_n(write_n),
  .addr_valid_n(addr_valid_n), .entry_valid_n_oe(entry_valid_n_oe),
  .match_address_bus(match_address_bus), .match_flag_n(match_flag_n),
  .full_flag_n(full_flag_n));
`default_nettype wire

// [tb/cdm_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cdm_defs.vh"
// ==========================================================
// controller model, one control state per call
module cdm_ctrl_model (
  input wire logic sys_clk,
  output logic cmd_sel,
  output logic [`CDM_OPW-1:0] op_code,
  output logic write_n,
  output logic addr_valid_n,
  output logic half_select,
  output logic [`CDM_HW-1:0] data_in
);
  initial begin
    cmd_sel = 1'b0;
    op_code = 12'h000;
    write_n = 1'b1;
    addr_valid_n = 1'b0;
    half_select = 1'b0;
    data_in = 32'h0;
  end
  task automatic issue(input logic [11:0] op, input logic wn, input logic hs,
    input logic [31:0] d);
    @(posedge sys_clk);
    cmd_sel <= 1'b1;
    op_code <= op;
    write_n <= wn;
    addr_valid_n <= 1'b1;
    // half select only for the two bus-half compares
    half_select <= hs & (op[5:0] inside {6'h19, 6'h1A});
    data_in <= d;
    @(posedge sys_clk);
    cmd_sel <= 1'b0;
    addr_valid_n <= 1'b0;
    // released bus must not look like the last word
    data_in <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/cam_data_move_and_compare_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cdm_defs.vh"
module cam_data_move_and_compare_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cascade_full_in_n = 1'b0;
  logic entry_valid_n_i = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ce = 1'b1;
  wire vb_o, vb_oe;
  wire cmd_sel, write_n, addr_valid_n, half_select, match_flag_n, full_flag_n;
  wire [11:0] op_code;
  wire [31:0] data_in, reg_rdata;
  wire [3:0] match_address_bus;
  logic [63:0] mem [16];
  logic [63:0] msk [8];
  logic [63:0] v [6];
  logic [63:0] cmp = 64'h0;
  logic [15:0] vld = 16'hFFFF;
  logic [15:0] hit = 16'h0;
  logic e_mf = 1'b1;
  logic [3:0] e_ma = 4'h0;
  logic [3:0] ar = 4'h0;
  logic [31:0] q, d, r;
  int err_total = 0;
  int check_count = 0;
  always #2 sys_clk = ~sys_clk;
  cdm_ctrl_model ctl (.sys_clk(sys_clk), .cmd_sel(cmd_sel), .op_code(op_code),
    .write_n(write_n), .addr_valid_n(addr_valid_n),
    .half_select(half_select), .data_in(data_in));
  cdm_core dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .cmd_sel(cmd_sel), .op_code(op_code), .write_n(write_n),
    .addr_valid_n(addr_valid_n), .half_select(half_select),
    .data_in(data_in), .cascade_full_in_n(cascade_full_in_n),
    .entry_valid_n_i(entry_valid_n_i), .entry_valid_n_o(vb_o),
    .entry_valid_n_oe(vb_oe), .match_address_bus(match_address_bus),
    .match_flag_n(match_flag_n), .full_flag_n(full_flag_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic end_of_test;
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] o);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    o = reg_rdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic set_cmp(input logic [63:0] c);
    wr(5'h00, c[31:0]);
    wr(5'h01, c[63:32]);
    cmp = c;
  endtask
  task automatic cmpchk;
    logic [31:0] lo;
    rd(5'h00, lo);
    rd(5'h01, q);
    chk("comparand", cmp, {q, lo});
  endtask
  task automatic srch(input logic [63:0] k, input logic [63:0] m);
    e_mf = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      hit[i] = !vld[i] && (((mem[i] ^ k) & ~m) == 64'h0);
      if (hit[i]) begin
        e_ma = i[3:0];
        e_mf = 1'b0;
      end
    end
  endtask
  task automatic cmd(input logic [11:0] op, input logic wn = 1'b0,
    input logic hs = 1'b0, input logic [31:0] x = 32'h0,
    input logic vin = 1'b0, input logic cfn = 1'b0);
    logic [63:0] m;
    logic [3:0] t;
    logic ok;
    m = msk[op[8:6]];
    ok = 1'b1;
    t = ar;
    // side inputs change on an edge, settled before the command edge
    @(posedge sys_clk);
    entry_valid_n_i <= vin;
    cascade_full_in_n <= cfn;
    ctl.issue(op, wn, hs, x);
    case (op[5:0])
      6'h0D: begin
        ok = !cfn && |vld;
        for (int i = 15; i >= 0; i--) if (vld[i]) t = i[3:0];
      end
      6'h0E: begin
        ok = !e_mf;
        t = e_ma;
      end
      6'h18: srch(cmp, m);
      6'h19: srch(hs ? {x, cmp[31:0]} : {cmp[63:32], x}, m);
      6'h1A: begin
        if (hs) cmp[63:32] = x;
        else cmp[31:0] = x;
        srch(cmp, m);
      end
      6'h1C: srch({~x, x}, {~x, x});
      6'h1B: begin
        hit[e_ma] = 1'b0;
        e_mf = ~|hit;
        for (int i = 15; i >= 0; i--) if (hit[i]) e_ma = i[3:0];
      end
      default: ;
    endcase
    if (op[5:0] inside {6'h0C, 6'h0D, 6'h0E} && ok) begin
      if (!wn) begin
        mem[t] = (mem[t] & m) | (cmp & ~m);
        vld[t] = vin;
      end else cmp = (cmp & m) | (mem[t] & ~m);
    end
    rd(5'h11, q);
    chk("match_flag_n", e_mf, q[31]);
    chk("full_flag_n", |vld, q[30]);
    if (!e_mf) chk("match_address", e_ma, q[3:0]);
    chk("entry_valid_n_oe", 64'h0, {63'h0, vb_oe});
    chk("entry_valid_n_o", 64'h1, {63'h0, vb_o});
  endtask
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hC619C2C1));
    for (int i = 0; i < 16; i++) mem[i] = 64'h0;
    for (int i = 0; i < 8; i++) msk[i] = 64'h0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(i[4:0], q);
      chk("reset_reg", 64'h0, {32'h0, q});
    end
    rd(5'h12, q);
    chk("unmapped", 64'h0, {32'h0, q});
    for (int i = 0; i < 6; i++) begin
      v[i] = {$urandom, $urandom};
      if (i == 3 || i == 5) v[i] = v[1];
      set_cmp(v[i]);
      cmd(12'h00D);
    end
    set_cmp(~v[0]);
    cmd(12'h00D, 1'b0, 1'b0, 32'h0, 1'b0, 1'b1);
    cmd(12'h018);
    set_cmp(v[1]);
    cmd(12'hE18);
    repeat (4) cmd(12'h01B);
    // a compare offered while the clock enable is low must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    ctl.issue(12'h018, 1'b0, 1'b0, 32'h0);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(5'h11, q);
    chk("frozen_match_flag", e_mf, q[31]);
    msk[1] = {$urandom, $urandom};
    wr(5'h02, msk[1][31:0]);
    wr(5'h03, msk[1][63:32]);
    set_cmp(v[0] ^ (msk[1] & {$urandom, $urandom}));
    cmd(12'hE58);
    for (int h = 0; h < 2; h++) begin
      r = $urandom;
      set_cmp(h ? {r, v[2][31:0]} : {v[2][63:32], r});
      cmd(12'h019, 1'b0, h[0], h ? v[2][63:32] : v[2][31:0]);
    end
    set_cmp(~v[4]);
    cmd(12'h05A, 1'b0, 1'b0, v[4][31:0]);
    cmd(12'h05A, 1'b0, 1'b1, v[4][63:32]);
    cmpchk();
    d = $urandom;
    r = $urandom;
    set_cmp({~d & r, d & r});
    wr(5'h10, 32'h8);
    ar = 4'h8;
    cmd(12'h00C);
    set_cmp(v[0]);
    cmd(12'h01C, 1'b0, 1'b0, d);
    cmpchk();
    rd(5'h03, q);
    chk("mask_hi", msk[1][63:32], q);
    cmd(12'h04E, 1'b1);
    cmpchk();
    cmd(12'h00C, 1'b1);
    cmpchk();
    set_cmp(v[5]);
    cmd(12'h04E, 1'b0, 1'b0, 32'h0, 1'b1);
    cmd(12'h018);
    cmd(12'h00C, 1'b1);
    cmpchk();
    // fill every empty word, then one more store must be refused
    while (|vld) cmd(12'h00D);
    cmd(12'h00D);
    end_of_test();
  end
endmodule
`default_nettype wire
